// ### design/t16ba_master.sv
// t16ba_master.sv: cpu-side end; axi4-lite slave turning wide commands into ordered byte pairs
// assumes: software writes CMD after WDATA; one command at a time
//
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
module t16ba_master
  import t16ba_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite slave
  input wire logic [11:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [11:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // byte bus
  t16ba_bus_if.master bus
);
  t16ba_state_t st_q; // sequencer
  logic [15:0] wval_q; // value to write
  logic [15:0] rval_q; // value read back
  logic [3:0] lo_q; // low-byte location of target
  logic is_wr_q; // command is a write
  logic busy_q; // command in progress
  logic aw_q, w_q; // captured halves of a write
  logic [11:0] awa_q;
  logic [31:0] wd_q;
  // ----------------------------------------
  // axi write: take address and data in either order
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 12'h000;
      wd_q <= 32'h0000_0000;
      s_awready <= 1'b1;
      s_wready <= 1'b1;
      s_bvalid <= 1'b0;
      s_bresp <= `T16BA_AXI_RESP_OK;
    end else if (ce) begin
      if (s_awvalid && s_awready) begin
        aw_q <= 1'b1;
        awa_q <= s_awaddr;
        s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_q <= 1'b1;
        wd_q <= s_wdata;
        s_wready <= 1'b0;
      end
      if (aw_q && w_q && !s_bvalid) begin
        s_bvalid <= 1'b1;
        s_bresp <= (awa_q == `T16BA_AXI_CMD || awa_q == `T16BA_AXI_WDATA) ? `T16BA_AXI_RESP_OK : `T16BA_AXI_RESP_ERR;
      end
      if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_awready <= 1'b1;
        s_wready <= 1'b1;
      end
    end
  end
  // ----------------------------------------
  // axi read: one-cycle answer
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b1;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= `T16BA_AXI_RESP_OK;
    end else if (ce) begin
      if (s_arvalid && s_arready) begin
        s_arready <= 1'b0;
        s_rvalid <= 1'b1;
        s_rresp <= `T16BA_AXI_RESP_OK;
        case (s_araddr)
          `T16BA_AXI_WDATA: s_rdata <= {16'h0000, wval_q};
          `T16BA_AXI_RDATA: s_rdata <= {16'h0000, rval_q};
          `T16BA_AXI_STAT: s_rdata <= {31'h0000_0000, busy_q};
          default: begin
            s_rdata <= 32'h0000_0000;
            s_rresp <= `T16BA_AXI_RESP_ERR;
          end
        endcase
      end else if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
        s_arready <= 1'b1;
      end
    end
  end
  // ----------------------------------------
  // byte sequencer: high then low on writes, low then high on reads
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= T16BA_S_IDLE;
      wval_q <= 16'h0000;
      rval_q <= 16'h0000;
      lo_q <= 4'h0;
      is_wr_q <= 1'b0;
      busy_q <= 1'b0;
      bus.addr <= 4'h0;
      bus.wdata <= 8'h00;
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
    end else if (ce) begin
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      // command taken as the write response is raised
      if (aw_q && w_q && !s_bvalid && awa_q == `T16BA_AXI_WDATA && s_wstrb[0]) wval_q <= wd_q[15:0];
      case (st_q)
        T16BA_S_IDLE: if (aw_q && w_q && !s_bvalid && awa_q == `T16BA_AXI_CMD && !busy_q) begin
          // cmd: bit 2 write, bits 1:0 wide register
          lo_q <= {1'b0, wd_q[1:0], 1'b0};
          is_wr_q <= wd_q[2];
          busy_q <= 1'b1;
          st_q <= T16BA_S_ST1;
        end
        T16BA_S_ST1: begin
          // whole pair issued back to back, no interrupt can split it
          bus.addr <= is_wr_q ? (lo_q | 4'h1) : lo_q;
          bus.wdata <= wval_q[15:8];
          bus.wr <= is_wr_q;
          bus.rd <= !is_wr_q;
          st_q <= T16BA_S_ST2;
        end
        T16BA_S_ST2: begin
          bus.addr <= is_wr_q ? lo_q : (lo_q | 4'h1);
          bus.wdata <= wval_q[7:0];
          bus.wr <= is_wr_q;
          bus.rd <= !is_wr_q;
          st_q <= T16BA_S_DONE;
        end
        T16BA_S_DONE: begin
          // first answer (high read still on the bus) is the low byte; the second is the high byte, from the latch for counter and capture
          if (bus.rvalid && bus.rd) rval_q[7:0] <= bus.rdata;
          if (is_wr_q) begin
            busy_q <= 1'b0;
            st_q <= T16BA_S_IDLE;
          end else if (bus.rvalid && bus.addr[0] && !bus.rd) begin
            rval_q[15:8] <= bus.rdata;
            busy_q <= 1'b0;
            st_q <= T16BA_S_IDLE;
          end
        end
        default: st_q <= T16BA_S_IDLE;
      endcase
    end
  end
endmodule // t16ba_master

// ### design/t16ba_defs.svh
// t16ba_defs.svh: offsets, field positions, reset values and fixed tops of the timer byte port
// assumes: included by bare name from the package and the bench
`ifndef T16BA_DEFS_SVH
`define T16BA_DEFS_SVH
// ----------------------------------------
// byte locations on the 8-bit bus
// ----------------------------------------
`define T16BA_ADR_CNT_LO 4'h0
`define T16BA_ADR_CNT_HI 4'h1
`define T16BA_ADR_CMPA_LO 4'h2
`define T16BA_ADR_CMPA_HI 4'h3
`define T16BA_ADR_CMPB_LO 4'h4
`define T16BA_ADR_CMPB_HI 4'h5
`define T16BA_ADR_CAP_LO 4'h6
`define T16BA_ADR_CAP_HI 4'h7
`define T16BA_ADR_CTRL_A 4'h8
`define T16BA_ADR_CTRL_B 4'h9
// ----------------------------------------
// control field positions
// ----------------------------------------
`define T16BA_CA_WM0 0
`define T16BA_CA_WM1 1
`define T16BA_CA_FOCB 2
`define T16BA_CA_FOCA 3
`define T16BA_CB_WM2 3
`define T16BA_CB_WM3 4
`define T16BA_CB_RUN 0
// ----------------------------------------
// counter constants and reset values
// ----------------------------------------
`define T16BA_BOTTOM 16'h0000
`define T16BA_MAX 16'hffff
`define T16BA_TOP8 16'h00ff
`define T16BA_TOP9 16'h01ff
`define T16BA_TOP10 16'h03ff
`define T16BA_RST16 16'h0000
`define T16BA_RST8 8'h00
// ----------------------------------------
// axi4-lite offsets of the controller's own registers
// ----------------------------------------
`define T16BA_AXI_CMD 12'h000
`define T16BA_AXI_WDATA 12'h004
`define T16BA_AXI_RDATA 12'h008
`define T16BA_AXI_STAT 12'h00c
`define T16BA_AXI_RESP_OK 2'b00
`define T16BA_AXI_RESP_ERR 2'b10
`endif

// ### design/t16ba_pkg.sv
// t16ba_pkg.sv: types shared by both ends of the timer byte port
// assumes: t16ba_defs.svh is on the include path
package t16ba_pkg;
  `include "t16ba_defs.svh"
  // which wide register a byte location belongs to
  typedef enum logic [1:0] {T16BA_W_CNT, T16BA_W_CMPA, T16BA_W_CMPB, T16BA_W_CAP} t16ba_wide_t;
  // controller sequencer states
  typedef enum logic [2:0] {T16BA_S_IDLE, T16BA_S_ST1, T16BA_S_ST2, T16BA_S_DONE} t16ba_state_t;
endpackage

// ### design/t16ba_bus_if.sv
// t16ba_bus_if.sv: 8-bit cpu-style byte bus between the timer and its master
// assumes: one clock shared by both ends; a strobe lasts one cycle
interface t16ba_bus_if;
  logic [3:0] addr; // byte location
  logic [7:0] wdata; // write byte
  logic wr; // write strobe, one cycle
  logic rd; // read strobe, one cycle
  logic [7:0] rdata; // read byte, registered, valid cycle after rd
  logic rvalid; // read answer marker
  modport timer (input addr, input wdata, input wr, input rd, output rdata, output rvalid);
  modport master (output addr, output wdata, output wr, output rd, input rdata, input rvalid);
endinterface

// ### design/t16ba_ctr.sv
// t16ba_ctr.sv: counter core with bottom, max and top detection
// assumes: same clock as the byte port; load has priority over counting
module t16ba_ctr
  import t16ba_pkg::*;
#(
  parameter int W = 16
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // control
  input wire logic run,
  input wire logic [3:0] mode,
  input wire logic [W-1:0] cmp_a,
  input wire logic [W-1:0] cap,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  // state
  output logic [W-1:0] count,
  output logic at_bottom,
  output logic at_max,
  output logic at_top
);
  logic [W-1:0] top; // current top of the sequence
  // top source chosen by the mode: fixed constant or a register
  always_comb begin
    case (mode)
      4'h1, 4'h5: top = `T16BA_TOP8;
      4'h2, 4'h6: top = `T16BA_TOP9;
      4'h3, 4'h7: top = `T16BA_TOP10;
      4'h4, 4'h9, 4'hb, 4'hf: top = cmp_a;
      4'h8, 4'ha, 4'hc, 4'he: top = cap;
      default: top = `T16BA_MAX;
    endcase
  end
  // full-width compares against bottom, max and the current top
  assign at_bottom = (count == `T16BA_BOTTOM);
  assign at_max = (count == `T16BA_MAX);
  assign at_top = (count == top);
  // up count with wrap at top; a cpu load always wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= `T16BA_RST16;
    end else if (ce) begin
      if (load) begin
        count <= load_val;
      end else if (run) begin
        count <= at_top ? `T16BA_BOTTOM : count + 1'b1;
      end
    end
  end
endmodule // t16ba_ctr

// ### design/t16ba_timer.sv
// t16ba_timer.sv: timer end; four wide registers reached over an 8-bit bus through one high-byte latch
// assumes: the master keeps high-first writes and low-first reads, with interrupts masked around them
// ----------------------------------------
// Overview of operation
// - bottom is 0x0000, max is 0xFFFF
// - top is fixed constant or compare/capture
// - wide registers take two byte accesses
// - one shared high-byte latch per timer
// - low-byte access performs the wide transfer
// - low write loads latch plus byte
// - low read copies high byte to latch
// - compare reads bypass latch, leave it
// - master writes high byte then low
// - master reads low byte then high
// - master masks interrupts around shared accesses
// - control a holds two force-compare bits
// - four-bit mode field, top two bits in b
// - high-byte location addresses the latch
// - cpu counter write beats count/clear
// ----------------------------------------
module t16ba_timer
  import t16ba_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // byte bus
  t16ba_bus_if.timer bus,
  // capture event and status
  input wire logic capture_evt,
  output logic [15:0] count_o,
  output logic bottom_o,
  output logic max_o,
  output logic top_o,
  output logic force_a_o,
  output logic force_b_o
);
  logic [7:0] hi_latch_q; // shared high-byte latch
  logic [15:0] cmp_a_q; // compare value a
  logic [15:0] cmp_b_q; // compare value b
  logic [15:0] cap_q; // capture value
  logic [7:0] ctrl_a_q; // control a
  logic [7:0] ctrl_b_q; // control b
  logic [3:0] mode; // waveform_mode_sel
  logic [15:0] count; // live counter
  logic bot, mx, tp;
  logic wr_cnt_lo; // wide counter load
  logic [15:0] wide_wr; // value loaded on a low-byte write
  logic cap_top; // capture register acts as top
  logic cap_s1_q, cap_s2_q; // capture pin synchroniser, two stages
  // ----------------------------------------
  // mode assembly and decode
  // ----------------------------------------
  assign mode = {ctrl_b_q[`T16BA_CB_WM3], ctrl_b_q[`T16BA_CB_WM2],
                 ctrl_a_q[`T16BA_CA_WM1], ctrl_a_q[`T16BA_CA_WM0]};
  assign wide_wr = {hi_latch_q, bus.wdata};
  assign wr_cnt_lo = bus.wr && (bus.addr == `T16BA_ADR_CNT_LO);
  // modes 8, 10, 12 and 14 take the capture register as top
  assign cap_top = mode[3] && !mode[0];
  // the capture pin is asynchronous; only the second stage is read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_s1_q <= 1'b0;
      cap_s2_q <= 1'b0;
    end else if (ce) begin
      cap_s1_q <= capture_evt;
      cap_s2_q <= cap_s1_q;
    end
  end
  t16ba_ctr #(.W(16)) u_ctr (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .run(ctrl_b_q[`T16BA_CB_RUN]),
    .mode(mode),
    .cmp_a(cmp_a_q),
    .cap(cap_q),
    .load(wr_cnt_lo),
    .load_val(wide_wr),
    .count(count),
    .at_bottom(bot),
    .at_max(mx),
    .at_top(tp)
  );
  // ----------------------------------------
  // shared latch: high writes and low reads
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hi_latch_q <= `T16BA_RST8;
    end else if (ce) begin
      if (bus.wr && bus.addr[0] && bus.addr < `T16BA_ADR_CTRL_A) begin
        hi_latch_q <= bus.wdata;
      end else if (bus.rd) begin
        case (bus.addr)
          `T16BA_ADR_CNT_LO: hi_latch_q <= count[15:8];
          `T16BA_ADR_CAP_LO: hi_latch_q <= cap_q[15:8];
          default: hi_latch_q <= hi_latch_q;
        endcase
      end
    end
  end
  // ----------------------------------------
  // wide registers: loaded by low-byte writes, capture also by the pin
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_a_q <= `T16BA_RST16;
      cmp_b_q <= `T16BA_RST16;
      cap_q <= `T16BA_RST16;
    end else if (ce) begin
      if (bus.wr && bus.addr == `T16BA_ADR_CMPA_LO) cmp_a_q <= wide_wr;
      if (bus.wr && bus.addr == `T16BA_ADR_CMPB_LO) cmp_b_q <= wide_wr;
      // capture register writable only when it defines top
      if (bus.wr && bus.addr == `T16BA_ADR_CAP_LO && cap_top) begin
        cap_q <= wide_wr;
      end else if (cap_s2_q && !cap_top) begin
        cap_q <= count;
      end
    end
  end
  // ----------------------------------------
  // control registers; force bits are strobes reading zero
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_a_q <= `T16BA_RST8;
      ctrl_b_q <= `T16BA_RST8;
      force_a_o <= 1'b0;
      force_b_o <= 1'b0;
    end else if (ce) begin
      force_a_o <= bus.wr && bus.addr == `T16BA_ADR_CTRL_A && bus.wdata[`T16BA_CA_FOCA];
      force_b_o <= bus.wr && bus.addr == `T16BA_ADR_CTRL_A && bus.wdata[`T16BA_CA_FOCB];
      if (bus.wr && bus.addr == `T16BA_ADR_CTRL_A) begin
        ctrl_a_q <= bus.wdata & ~(8'h01 << `T16BA_CA_FOCA) & ~(8'h01 << `T16BA_CA_FOCB);
      end
      if (bus.wr && bus.addr == `T16BA_ADR_CTRL_B) ctrl_b_q <= bus.wdata;
    end
  end
  // ----------------------------------------
  // read answer, one cycle after the strobe
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus.rdata <= `T16BA_RST8;
      bus.rvalid <= 1'b0;
    end else if (ce) begin
      bus.rvalid <= bus.rd;
      if (bus.rd) begin
        case (bus.addr)
          `T16BA_ADR_CNT_LO: bus.rdata <= count[7:0];
          `T16BA_ADR_CMPA_LO: bus.rdata <= cmp_a_q[7:0];
          `T16BA_ADR_CMPA_HI: bus.rdata <= cmp_a_q[15:8];
          `T16BA_ADR_CMPB_LO: bus.rdata <= cmp_b_q[7:0];
          `T16BA_ADR_CMPB_HI: bus.rdata <= cmp_b_q[15:8];
          `T16BA_ADR_CAP_LO: bus.rdata <= cap_q[7:0];
          `T16BA_ADR_CNT_HI, `T16BA_ADR_CAP_HI: bus.rdata <= hi_latch_q;
          `T16BA_ADR_CTRL_A: bus.rdata <= ctrl_a_q;
          `T16BA_ADR_CTRL_B: bus.rdata <= ctrl_b_q;
          default: bus.rdata <= 8'h00;
        endcase
      end
    end
  end
  // ----------------------------------------
  // registered status outputs
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_o <= `T16BA_RST16;
      bottom_o <= 1'b0;
      max_o <= 1'b0;
      top_o <= 1'b0;
    end else if (ce) begin
      count_o <= count;
      bottom_o <= bot;
      max_o <= mx;
      top_o <= tp;
    end
  end
endmodule // t16ba_timer

// ### tb/t16ba_props.sv
// t16ba_props.sv: assertions on the byte bus between the timer end and the master end
// assumes: instanced beside the bus interface; ctrl registers keep their reset mode, so top is ffff
module t16ba_props (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // byte bus
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  // timer state
  input wire logic [15:0] count_o,
  input wire logic bottom_o,
  input wire logic max_o,
  input wire logic top_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // helpers
  // ----
  logic [7:0] cnt_lo; // counter halves, so $past sees a plain signal
  logic [7:0] cnt_hi;
  assign cnt_lo = count_o[7:0];
  assign cnt_hi = count_o[15:8];
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // a complete counter write: high byte, then low byte
  sequence s_cnt_wr;
    (wr && addr == 4'h1) ##1 (wr && addr == 4'h0);
  endsequence
  // a complete counter read: low byte, then high byte
  sequence s_cnt_rd;
    (rd && addr == 4'h0) ##1 (rd && addr == 4'h1);
  endsequence
  // ----
  // properties
  // ----
  property p_rd_answer;
    rd |=> rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read strobe got no answer");
  property p_rv_cause;
    rvalid |-> $past(rd);
  endproperty
  a_rv_cause: assert property (p_rv_cause) else $error("answer without a read");
  property p_wr_order;
    wr && !addr[0] && !addr[3] |-> $past(wr) && $past(addr) == addr + 4'h1;
  endproperty
  a_wr_order: assert property (p_wr_order) else $error("low write not after high write");
  property p_rd_order;
    rd && addr[0] && !addr[3] |-> $past(rd) && $past(addr) == addr - 4'h1;
  endproperty
  a_rd_order: assert property (p_rd_order) else $error("high read not after low read");
  property p_lo_write;
    s_cnt_wr |-> ##2 count_o == {$past(wdata, 3), $past(wdata, 2)};
  endproperty
  a_lo_write: assert property (p_lo_write) else $error("counter not loaded from latch and low");
  // the counter is stopped in this bench, so a high write alone must leave it
  property p_hi_only;
    wr && addr == 4'h1 |=> $stable(count_o);
  endproperty
  a_hi_only: assert property (p_hi_only) else $error("high write moved the counter");
  property p_lo_read;
    rd && addr == 4'h0 |=> rvalid && rdata == $past(cnt_lo);
  endproperty
  a_lo_read: assert property (p_lo_read) else $error("low read returned wrong byte");
  property p_hi_latch;
    s_cnt_rd |=> rdata == $past(cnt_hi, 2);
  endproperty
  a_hi_latch: assert property (p_hi_latch) else $error("high read not from latched copy");
  property p_bottom;
    $stable(count_o) [*3] |-> bottom_o == (count_o == 16'h0000);
  endproperty
  a_bottom: assert property (p_bottom) else $error("bottom flag wrong");
  property p_max;
    $stable(count_o) [*3] |-> max_o == (count_o == 16'hffff);
  endproperty
  a_max: assert property (p_max) else $error("max flag wrong");
  // mode 0 has the fixed top ffff
  property p_top;
    $stable(count_o) [*3] |-> top_o == (count_o == 16'hffff);
  endproperty
  a_top: assert property (p_top) else $error("top flag wrong");
endmodule // t16ba_props

// ### tb/t16ba_bench.sv
// t16ba_bench.sv: self-checking bench; axi4-lite drives the master end, which talks to the timer end
// assumes: design files and t16ba_defs.svh compiled first; ctrl registers stay at reset (mode 0, stopped)
`include "t16ba_defs.svh"
module t16ba_bench;
  import t16ba_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // clock, reset and capture input
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic capture_evt = 1'b0;
  // axi4-lite master side
  logic [11:0] s_awaddr = 12'h000;
  logic s_awvalid = 1'b0;
  logic [31:0] s_wdata = 32'h0;
  logic [3:0] s_wstrb = 4'hf;
  logic s_wvalid = 1'b0;
  logic s_bready = 1'b0;
  logic [11:0] s_araddr = 12'h000;
  logic s_arvalid = 1'b0;
  logic s_rready = 1'b0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp;
  logic [31:0] s_rdata;
  // timer outputs
  logic [15:0] count_o;
  logic bottom_o, max_o, top_o;
  // scoreboard: model of the four wide registers
  int error_cnt = 0;
  int n_checks = 0;
  int mdl [4] = '{0, 0, 0, 0};
  t16ba_bus_if t16ba_bus_if_i ();
  t16ba_timer t16ba_timer_i (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .bus(t16ba_bus_if_i),
    .capture_evt(capture_evt), .count_o(count_o), .bottom_o(bottom_o), .max_o(max_o), .top_o(top_o),
    .force_a_o(), .force_b_o());
  t16ba_master t16ba_master_i (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .bus(t16ba_bus_if_i));
  t16ba_props t16ba_props_i (.aclk(aclk), .aresetn(aresetn), .addr(t16ba_bus_if_i.addr),
    .wdata(t16ba_bus_if_i.wdata), .wr(t16ba_bus_if_i.wr), .rd(t16ba_bus_if_i.rd),
    .rdata(t16ba_bus_if_i.rdata), .rvalid(t16ba_bus_if_i.rvalid), .count_o(count_o),
    .bottom_o(bottom_o), .max_o(max_o), .top_o(top_o));
  // 100 mhz clock
  initial begin
    forever #5 aclk = ~aclk;
  end
  // ----
  // checking and closing
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ----
  // axi4-lite cycles: each channel held until its own ready is sampled
  // ----
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge aclk);
    s_awaddr <= a;
    s_awvalid <= 1'b1;
    s_wdata <= d;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (aw && s_awready === 1'b1) begin
        s_awvalid <= 1'b0;
        aw = 1'b0;
      end
      if (w && s_wready === 1'b1) begin
        s_wvalid <= 1'b0;
        w = 1'b0;
      end
    end while (s_bvalid !== 1'b1);
    s_bready <= 1'b0;
    r = s_bresp;
  endtask
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar;
    ar = 1'b1;
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (ar && s_arready === 1'b1) begin
        s_arvalid <= 1'b0;
        ar = 1'b0;
      end
    end while (s_rvalid !== 1'b1);
    s_rready <= 1'b0;
    d = s_rdata;
    r = s_rresp;
  endtask
  // busy rises in the same cycle as the command's response; one edge is still skipped before polling
  task automatic wide_cmd(input logic wr_n, input logic [1:0] k);
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(`T16BA_AXI_CMD, {29'h0, wr_n, k}, r);
    chk(r, `T16BA_AXI_RESP_OK);
    @(posedge aclk);
    do axi_rd(`T16BA_AXI_STAT, d, r); while (d[0] !== 1'b0);
  endtask
  task automatic wide_wr(input logic [1:0] k, input logic [15:0] v);
    logic [1:0] r;
    axi_wr(`T16BA_AXI_WDATA, {16'h0000, v}, r);
    wide_cmd(1'b1, k);
  endtask
  task automatic wide_rd(input logic [1:0] k, output logic [15:0] v);
    logic [31:0] d;
    logic [1:0] r;
    wide_cmd(1'b0, k);
    axi_rd(`T16BA_AXI_RDATA, d, r);
    v = d[15:0];
  endtask
  // ----
  // tests
  // ----
  initial begin
    logic [15:0] v;
    logic [31:0] d;
    logic [1:0] r;
    logic [1:0] k;
    logic [15:0] vals [4];
    void'($urandom(32'h0ca7));
    vals = '{16'h0000, 16'hffff, 16'h00ff, 16'h0000};
    vals[3] = 16'($urandom);
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    wide_rd(2'd0, v);
    chk(v, 32'h0);
    // counter boundaries and a random value, each written then read back
    foreach (vals[i]) begin
      wide_wr(2'd0, vals[i]);
      mdl[0] = vals[i];
      chk(count_o, mdl[0]);
      chk(bottom_o, mdl[0] == 0);
      chk(max_o, mdl[0] == 'hffff);
      chk(top_o, mdl[0] == 'hffff);
      wide_rd(2'd0, v);
      chk(v, mdl[0]);
    end
    // capture copies the count; a capture write is refused while it is not the top source
    capture_evt <= 1'b1;
    @(posedge aclk);
    capture_evt <= 1'b0;
    mdl[3] = mdl[0];
    wide_rd(2'd3, v);
    chk(v, mdl[3]);
    wide_wr(2'd3, 16'(~mdl[3]));
    wide_rd(2'd3, v);
    chk(v, mdl[3]);
    // random writes to counter and both compares, all three read back after each: the latch is shared
    repeat (8) begin
      k = 2'($urandom_range(2));
      v = 16'($urandom);
      wide_wr(k, v);
      mdl[k] = v;
      for (int j = 0; j < 3; j++) begin
        wide_rd(2'(j), v);
        chk(v, mdl[j]);
      end
    end
    // unmapped locations are refused
    axi_wr(12'h010, 32'h0, r);
    chk(r, `T16BA_AXI_RESP_ERR);
    axi_rd(12'h020, d, r);
    chk(r, `T16BA_AXI_RESP_ERR);
    summarize();
  end
  // watchdog: the tests need under a thousand cycles
  initial begin
    repeat (40000) @(posedge aclk);
    error_cnt++;
    summarize();
  end
endmodule // t16ba_bench
